// *** core/twrs_pkg.sv ***
// Notes on behaviour
// (RL1) slave only, up to 100 kbit/s
// (RL2) start: sda falls while scl high
// (RL3) stop: sda rises while scl high
// (RL4) repeated start acts as start, bus busy
// (RL5) sda changes only while scl low
// (RL6) master makes every scl pulse
// (RL7) drive sda only for ack or read data
// (RL8) master shifts on fall, samples on rise; the bench master samples at the end of scl high, just before the fall
// (RL9) eight bits msb first, then ack bit
// (RL10) receiver acks every byte
// (RL11) master nack ends read, slave releases
// (RL12) master clocks every ack bit
// (RL13) first byte: address then direction bit
// (RL14) ack on match, pick direction; else silent
// (RL15) bus address is 0x58
// (RL16) write: addr, index, data, stop
// (RL17) read: addr, index, restart, addr, data
// (RL18) sample rate is clock over 8 times divisor
// (RL19) pwm rate is clock over 4096 times n+1
// (RL20) stop or mismatch returns to idle; a nack goes to ST_WAIT and stays there until the next stop or start
package twrs_pkg;
	localparam logic [6:0] SLAVE_ADDR = 7'h58;
	localparam logic [7:0] PWM_DIV_OFS = 8'h05;
	localparam logic [7:0] SAMP_HI_OFS = 8'h06;
	localparam logic [7:0] SAMP_LO_OFS = 8'h07;
	localparam logic [7:0] PWM_DIV_RST = 8'h00;
	localparam logic [7:0] SAMP_HI_RST = 8'h00;
	localparam logic [7:0] SAMP_LO_RST = 8'h01;
	localparam int SAMP_PRESCALE = 8;
	localparam int PWM_PRESCALE = 4096;
	localparam int PWM_PRE_W = 12;
	localparam int SAMP_PRE_W = 3;
	localparam int NUM_REGS = 8;

	typedef enum logic [6:0] {
		ST_IDLE = 7'b000_0001,
		ST_ADDR = 7'b000_0010,
		ST_ACK = 7'b000_0100,
		ST_RX = 7'b000_1000,
		ST_TX = 7'b001_0000,
		ST_TXACK = 7'b010_0000,
		ST_WAIT = 7'b100_0000
	} twrs_state_t;
endpackage

// *** core/twrs_regmem.sv ***
`timescale 1ns/1ps
// small register store, registered read data
module twrs_regmem (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic wr_en,
	input wire logic [7:0] wr_idx,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_idx,
	output logic [7:0] rd_data,
	output logic [7:0] pwm_div,
	output logic [15:0] samp_div
);
	logic [7:0] mem_r [twrs_pkg::NUM_REGS];

	function automatic logic hit(input logic [7:0] idx);
		hit = (idx < 8'(twrs_pkg::NUM_REGS));
	endfunction

	genvar g;
	generate
		for (g = 0; g < twrs_pkg::NUM_REGS; g++)
		begin : g_reg
			always_ff @(posedge ref_clk or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					if (g == int'(twrs_pkg::SAMP_LO_OFS))
						mem_r[g] <= twrs_pkg::SAMP_LO_RST;
					else if (g == int'(twrs_pkg::SAMP_HI_OFS))
						mem_r[g] <= twrs_pkg::SAMP_HI_RST;
					else
						mem_r[g] <= twrs_pkg::PWM_DIV_RST;
				end
				else if (wr_en && hit(wr_idx) && wr_idx[2:0] == 3'(g))
					mem_r[g] <= wr_data; // see (RL16)
			end
		end
	endgenerate

	// unmapped index reads zero
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			rd_data <= 8'h00;
		else
			rd_data <= hit(rd_idx) ? mem_r[rd_idx[2:0]] : 8'h00;
	end

	assign pwm_div = mem_r[twrs_pkg::PWM_DIV_OFS[2:0]];
	assign samp_div = {mem_r[twrs_pkg::SAMP_HI_OFS[2:0]],
		mem_r[twrs_pkg::SAMP_LO_OFS[2:0]]};
endmodule // twrs_regmem

// *** core/twrs_ratediv.sv ***
`timescale 1ns/1ps
// prescale then divide; one-cycle tick per period
module twrs_ratediv #(
	parameter int PRE_W = 3,
	parameter int DIV_W = 16,
	parameter bit PLUS_ONE = 1'b0
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [DIV_W-1:0] div,
	output logic tick
);
	logic [PRE_W-1:0] pre_r;
	logic [DIV_W-1:0] cnt_r;
	logic [DIV_W-1:0] last;
	logic pre_wrap;

	assign pre_wrap = &pre_r;
	// divisor of zero treated as one, avoids a stuck tick
	assign last = PLUS_ONE ? div : ((div == '0) ? '0 : div - 1'b1);

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pre_r <= '0;
			cnt_r <= '0;
			tick <= 1'b0;
		end
		else
		begin
			pre_r <= pre_r + 1'b1;
			tick <= 1'b0;
			if (pre_wrap)
			begin
				if (cnt_r >= last)
				begin
					cnt_r <= '0;
					tick <= 1'b1;
				end
				else
					cnt_r <= cnt_r + 1'b1;
			end
		end
	end
endmodule // twrs_ratediv

// *** core/twrs_slave.sv ***
`timescale 1ns/1ps
module twrs_slave (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic bus_busy,
	output logic sample_tick,
	output logic pwm_tick,
	output logic [7:0] pwm_rate_divisor,
	output logic [15:0] sample_rate_divisor
);
	twrs_pkg::twrs_state_t state_r, state_nxt;
	logic scl_q_r;
	logic sda_q_r;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic [7:0] shift_r;
	logic [3:0] bit_r;
	logic rw_r;
	logic idx_seen_r;
	logic [7:0] idx_r;
	logic wr_en_r;
	logic [7:0] wr_data_r;
	logic [7:0] rd_data;
	logic [7:0] pwm_div;
	logic [15:0] samp_div;
	logic samp_tick_w;
	logic pwm_tick_w;
	logic addr_match;
	logic byte_done;
	logic tx_first;

	// inputs already synchronous to ref_clk
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end
		else
		begin
			scl_q_r <= scl_in;
			sda_q_r <= sda_in;
		end
	end

	assign scl_rise = scl_in && !scl_q_r; // see (RL6) (RL8)
	assign scl_fall = !scl_in && scl_q_r;
	assign start_det = scl_in && scl_q_r && sda_q_r && !sda_in; // see (RL2)
	assign stop_det = scl_in && scl_q_r && !sda_q_r && sda_in; // see (RL3)
	assign byte_done = scl_rise && (bit_r == 4'd7);
	// lsb of the first byte is the direction bit, not address
	assign addr_match = (shift_r[7:1] == twrs_pkg::SLAVE_ADDR); // see (RL15)
	// first bit of a byte: after the address ack or a master ack
	assign tx_first = (state_r == twrs_pkg::ST_ACK) || (bit_r == 4'd8);

	// busy from start to stop; restart keeps it set
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			bus_busy <= 1'b0;
		else if (start_det)
			bus_busy <= 1'b1; // see (RL4)
		else if (stop_det)
			bus_busy <= 1'b0; // see (RL3)
	end

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			twrs_pkg::ST_IDLE: ;
			twrs_pkg::ST_ADDR:
				if (scl_fall && bit_r == 4'd8)
					// see (RL13) (RL14)
					state_nxt = addr_match ? twrs_pkg::ST_ACK
						: twrs_pkg::ST_IDLE; // see (RL20)
			twrs_pkg::ST_ACK:
				if (scl_fall)
					state_nxt = rw_r ? twrs_pkg::ST_TX : twrs_pkg::ST_RX;
			twrs_pkg::ST_RX:
				if (scl_fall && bit_r == 4'd8)
					state_nxt = twrs_pkg::ST_ACK; // see (RL10)
			twrs_pkg::ST_TX:
				// last data bit ends here; next rise is the master's ack
				if (scl_fall && bit_r == 4'd7)
					state_nxt = twrs_pkg::ST_TXACK;
			twrs_pkg::ST_TXACK:
				if (scl_rise)
					// see (RL11) (RL20)
					state_nxt = sda_in ? twrs_pkg::ST_WAIT
						: twrs_pkg::ST_TX;
			twrs_pkg::ST_WAIT: ;
			default: state_nxt = twrs_pkg::ST_IDLE;
		endcase
		if (state_r == twrs_pkg::ST_TXACK && !scl_rise && scl_fall)
			state_nxt = state_r;
		if (stop_det)
			state_nxt = twrs_pkg::ST_IDLE; // see (RL20)
		if (start_det)
			state_nxt = twrs_pkg::ST_ADDR; // see (RL2) (RL4)
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			state_r <= twrs_pkg::ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// bit counter: 0..7 data bits, 8 marks the ninth bit window
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			bit_r <= 4'd0;
		else if (start_det)
			bit_r <= 4'd0;
		else if (scl_fall && bit_r == 4'd8)
			bit_r <= 4'd0;
		else if (scl_fall && state_r == twrs_pkg::ST_TXACK)
			bit_r <= 4'd0;
		else if (scl_rise && bit_r < 4'd8 &&
			(state_r == twrs_pkg::ST_ADDR || state_r == twrs_pkg::ST_RX))
			bit_r <= bit_r + 4'd1; // see (RL9)
		else if (scl_fall && state_r == twrs_pkg::ST_TX)
			bit_r <= bit_r + 4'd1;
	end

	// receive shifter, msb first, sampled on scl rise
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			shift_r <= 8'h00;
		else if (scl_rise && bit_r < 4'd8 &&
			(state_r == twrs_pkg::ST_ADDR || state_r == twrs_pkg::ST_RX))
			shift_r <= {shift_r[6:0], sda_in}; // see (RL9)
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			rw_r <= 1'b0;
		else if (state_r == twrs_pkg::ST_ADDR && byte_done)
			rw_r <= sda_in; // see (RL13)
	end

	// first write byte is the index, later ones are data
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			idx_seen_r <= 1'b0;
			idx_r <= 8'h00;
			wr_en_r <= 1'b0;
			wr_data_r <= 8'h00;
		end
		else
		begin
			wr_en_r <= 1'b0;
			if (state_r == twrs_pkg::ST_ADDR)
				idx_seen_r <= 1'b0;
			if (state_r == twrs_pkg::ST_RX && scl_fall && bit_r == 4'd8)
			begin
				if (!idx_seen_r)
				begin
					idx_r <= shift_r; // see (RL16) (RL17)
					idx_seen_r <= 1'b1;
				end
				else
				begin
					wr_en_r <= 1'b1; // see (RL16)
					wr_data_r <= shift_r;
				end
			end
			// further data bytes land in following registers
			if (wr_en_r)
				idx_r <= idx_r + 8'd1;
		end
	end

	function automatic logic tx_bit(input logic [3:0] n);
		tx_bit = rd_data[3'd7 - n[2:0]];
	endfunction

	// sda driver: changed on scl fall or released at start/stop, else held while scl high
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sda_out <= 1'b1;
			sda_oe <= 1'b0;
		end
		else if (start_det || stop_det)
		begin
			sda_out <= 1'b1;
			sda_oe <= 1'b0; // see (RL20)
		end
		else if (scl_fall) // see (RL5)
		begin
			sda_out <= 1'b1;
			sda_oe <= 1'b0;
			if ((state_r == twrs_pkg::ST_ADDR && bit_r == 4'd8 &&
				addr_match) ||
				(state_r == twrs_pkg::ST_RX && bit_r == 4'd8))
			begin
				sda_out <= 1'b0; // see (RL7) (RL14)
				sda_oe <= 1'b1;
			end
			else if ((state_r == twrs_pkg::ST_ACK && rw_r) ||
				(state_r == twrs_pkg::ST_TX &&
				(bit_r < 4'd7 || bit_r == 4'd8)))
			begin
				// open drain: only low is driven
				// a master ack replays the same register
				sda_out <= 1'b0;
				sda_oe <= !tx_bit(tx_first ? 4'd0
					: bit_r + 4'd1); // see (RL7) (RL9)
			end
		end
	end

	// sensor and pwm rate ticks
	twrs_ratediv #(
		.PRE_W(twrs_pkg::SAMP_PRE_W),
		.DIV_W(16),
		.PLUS_ONE(1'b0)
	) u_samp (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.div(samp_div),
		.tick(samp_tick_w)
	); // see (RL18)

	twrs_ratediv #(
		.PRE_W(twrs_pkg::PWM_PRE_W),
		.DIV_W(8),
		.PLUS_ONE(1'b1)
	) u_pwm (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.div(pwm_div),
		.tick(pwm_tick_w)
	); // see (RL19)

	twrs_regmem u_mem (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.wr_en(wr_en_r),
		.wr_idx(idx_r),
		.wr_data(wr_data_r),
		.rd_idx(idx_r),
		.rd_data(rd_data),
		.pwm_div(pwm_div),
		.samp_div(samp_div)
	);

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sample_tick <= 1'b0;
			pwm_tick <= 1'b0;
			pwm_rate_divisor <= twrs_pkg::PWM_DIV_RST;
			sample_rate_divisor <= {twrs_pkg::SAMP_HI_RST,
				twrs_pkg::SAMP_LO_RST};
		end
		else
		begin
			sample_tick <= samp_tick_w;
			pwm_tick <= pwm_tick_w;
			pwm_rate_divisor <= pwm_div;
			sample_rate_divisor <= samp_div;
		end
	end

	sequence s_start;
		scl_in && scl_q_r && sda_q_r && !sda_in;
	endsequence

	sequence s_addr_hit;
		state_r == twrs_pkg::ST_ADDR && scl_fall && bit_r == 4'd8
		&& addr_match && !start_det && !stop_det;
	endsequence

	sequence s_pwm_write;
		wr_en_r && idx_r == twrs_pkg::PWM_DIV_OFS;
	endsequence

	a_start_busy: assert property ( // see (RL2)
		@(posedge ref_clk) disable iff (sys_rst)
		s_start |=> bus_busy)
		else $error("start did not mark bus busy");
	a_stop_free: assert property ( // see (RL3)
		@(posedge ref_clk) disable iff (sys_rst)
		stop_det && !start_det |=> !bus_busy && !sda_oe)
		else $error("stop did not free bus");
	a_restart_addr: assert property ( // see (RL4)
		@(posedge ref_clk) disable iff (sys_rst)
		s_start |=> state_r == twrs_pkg::ST_ADDR)
		else $error("restart not handled as start");
	a_busy_hold: assert property ( // see (RL4)
		@(posedge ref_clk) disable iff (sys_rst)
		bus_busy && !stop_det |=> bus_busy)
		else $error("bus freed without stop");
	a_sda_stable: assert property ( // see (RL5)
		@(posedge ref_clk) disable iff (sys_rst)
		scl_in && scl_q_r |=> $stable(sda_oe) || $past(start_det)
		|| $past(stop_det))
		else $error("sda changed while scl high");
	a_drive_only: assert property ( // see (RL7)
		@(posedge ref_clk) disable iff (sys_rst)
		sda_oe |-> state_r != twrs_pkg::ST_IDLE)
		else $error("sda driven while idle");
	a_never_high: assert property ( // see (RL1)
		@(posedge ref_clk) disable iff (sys_rst)
		sda_oe |-> !sda_out)
		else $error("sda driven high");
	a_addr_ack: assert property ( // see (RL14) (RL15)
		@(posedge ref_clk) disable iff (sys_rst)
		s_addr_hit |=> sda_oe && state_r == twrs_pkg::ST_ACK)
		else $error("address match not acknowledged");
	a_ack_release: assert property ( // see (RL7) (RL10)
		@(posedge ref_clk) disable iff (sys_rst)
		state_r == twrs_pkg::ST_ACK && scl_fall && !rw_r
		&& !start_det && !stop_det |=> !sda_oe)
		else $error("ack held past its bit");
	a_tx_release: assert property ( // see (RL7) (RL11)
		@(posedge ref_clk) disable iff (sys_rst)
		state_r == twrs_pkg::ST_TX && scl_fall && bit_r == 4'd7
		&& !start_det && !stop_det
		|=> !sda_oe && state_r == twrs_pkg::ST_TXACK)
		else $error("sda not released for master ack");
	a_wait_quiet: assert property ( // see (RL11) (RL20)
		@(posedge ref_clk) disable iff (sys_rst)
		state_r == twrs_pkg::ST_WAIT |-> !sda_oe)
		else $error("sda driven after nack");
	a_wr_strobe: assert property ( // see (RL16)
		@(posedge ref_clk) disable iff (sys_rst)
		wr_en_r |-> idx_seen_r)
		else $error("write before index");
	a_pwm_store: assert property ( // see (RL16) (RL19)
		@(posedge ref_clk) disable iff (sys_rst)
		s_pwm_write |-> ##2 pwm_rate_divisor == $past(wr_data_r, 2))
		else $error("pwm divisor write not stored");
	a_tick_single: assert property ( // see (RL18)
		@(posedge ref_clk) disable iff (sys_rst)
		sample_tick |=> !sample_tick)
		else $error("sample tick longer than one cycle");
	a_mismatch_idle: assert property ( // see (RL14) (RL20)
		@(posedge ref_clk) disable iff (sys_rst)
		state_r == twrs_pkg::ST_ADDR && scl_fall && bit_r == 4'd8
		&& !addr_match && !start_det && !stop_det
		|=> state_r == twrs_pkg::ST_IDLE && !sda_oe)
		else $error("mismatch did not return idle");
	a_nack_wait: assert property ( // see (RL11)
		@(posedge ref_clk) disable iff (sys_rst)
		state_r == twrs_pkg::ST_TXACK && scl_rise && sda_in
		&& !start_det && !stop_det
		|=> state_r == twrs_pkg::ST_WAIT)
		else $error("nack did not end read");
endmodule // twrs_slave

// *** verif/twrs_bus_master.sv ***
`timescale 1ns/1ps
// bus master model; scl stands high between frames
module twrs_bus_master #(
	parameter int HALF = 5
) (
	input wire logic ref_clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_m
);
	initial
	begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic wt();
		repeat (HALF) @(negedge ref_clk);
	endtask
	// start and repeated start share one shape
	task automatic start();
		@(negedge ref_clk);
		sda_m = 1'b1;
		wt();
		scl = 1'b1;
		wt();
		sda_m = 1'b0;
		wt();
		scl = 1'b0;
	endtask
	task automatic stop();
		@(negedge ref_clk);
		sda_m = 1'b0;
		wt();
		scl = 1'b1;
		wt();
		sda_m = 1'b1;
		wt();
	endtask
	// one cycle after scl falls, so data never moves with it
	task automatic bit_io(input logic b, output logic r);
		@(negedge ref_clk);
		sda_m = b;
		wt();
		scl = 1'b1;
		wt();
		r = sda_line;
		scl = 1'b0;
	endtask
	task automatic put(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic get(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask
endmodule // twrs_bus_master

// *** verif/two_wire_register_slave_bench.sv ***
`timescale 1ns/1ps
module two_wire_register_slave_bench;
	logic ref_clk;
	logic sys_rst;
	logic scl;
	logic sda_m;
	logic sda_line;
	logic sda_out;
	logic sda_oe;
	logic bus_busy;
	logic sample_tick;
	logic pwm_tick;
	logic [7:0] pwm_rate_divisor;
	logic [15:0] sample_rate_divisor;
	logic [2:0] ak;
	logic p_scl = 1'b1;
	logic p_oe = 1'b0;
	logic [31:0] seed = 32'he522_189d;
	int n_errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	int mem [8];
	// pull-up: low when either side pulls
	assign sda_line = sda_m & ~(sda_oe & ~sda_out);
	twrs_slave i_dut (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.scl_in(scl),
		.sda_in(sda_line),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.bus_busy(bus_busy),
		.sample_tick(sample_tick),
		.pwm_tick(pwm_tick),
		.pwm_rate_divisor(pwm_rate_divisor),
		.sample_rate_divisor(sample_rate_divisor)
	);
	twrs_bus_master i_mst (
		.ref_clk(ref_clk),
		.sda_line(sda_line),
		.scl(scl),
		.sda_m(sda_m)
	);
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// slave side of sda may only move while scl is low
	always @(posedge ref_clk)
	begin
		if (p_scl && scl && sda_oe !== p_oe)
			chk(sda_oe, p_oe);
		if (sda_oe && sda_out !== 1'b0)
			chk(sda_out, 1'b0);
		p_scl <= scl;
		p_oe <= sda_oe;
		cyc++;
		if (cyc == 60000)
		begin
			n_errors++;
			final_report();
		end
	end
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		i_mst.start();
		i_mst.put(8'hb0, ak[2]);
		i_mst.put(i, ak[1]);
		i_mst.put(d, ak[0]);
		i_mst.stop();
		if (i < 8)
			mem[i] = d;
	endtask
	task automatic rd(input logic [7:0] i, output logic [7:0] d);
		i_mst.start();
		i_mst.put(8'hb0, ak[2]);
		i_mst.put(i, ak[1]);
		i_mst.start();
		chk(bus_busy, 1'b1);
		i_mst.put(8'hb1, ak[0]);
		i_mst.get(1'b1, d);
		i_mst.stop();
	endtask
	// waits a tick, then counts cycles to the next
	task automatic gap(input bit pw, output int n);
		n = 0;
		do
			@(negedge ref_clk);
		while (pw ? !pwm_tick : !sample_tick);
		do
		begin
			@(negedge ref_clk);
			n++;
		end
		while (pw ? !pwm_tick : !sample_tick);
	endtask
	initial
	begin
		logic [7:0] d;
		logic [7:0] q;
		logic [6:0] a;
		int n;
		sys_rst = 1'b1;
		mem = '{0, 0, 0, 0, 0, 0, 0, 1};
		repeat (8) @(negedge ref_clk);
		sys_rst = 1'b0;
		chk(pwm_rate_divisor, mem[5]);
		chk(sample_rate_divisor, mem[6] * 256 + mem[7]);
		// two slots past the map; small pwm divisor and sample high byte keep tick runs short
		for (int i = 0; i < 10; i++)
		begin
			d = rnd();
			if (i inside {5, 6})
				d &= 8'h01;
			wr(i[7:0], d);
			chk(ak, 3'b111);
			chk(bus_busy, 1'b0);
			rd(i[7:0], q);
			chk(ak, 3'b111);
			chk(q, i < 8 ? mem[i] : 0);
		end
		chk(pwm_rate_divisor, mem[5]);
		chk(sample_rate_divisor, mem[6] * 256 + mem[7]);
		// mid-run reset with the bus idle: settings fall back
		sys_rst = 1'b1;
		repeat (2) @(negedge ref_clk);
		sys_rst = 1'b0;
		mem = '{0, 0, 0, 0, 0, 0, 0, 1};
		chk(pwm_rate_divisor, mem[5]);
		chk(sample_rate_divisor, mem[6] * 256 + mem[7]);
		chk(bus_busy, 1'b0);
		wr(8'h05, 8'h01);
		chk(ak, 3'b111);
		for (int k = 0; k < 4; k++)
		begin
			a = 7'(8'h58 ^ (rnd() | 8'h01));
			i_mst.start();
			chk(bus_busy, 1'b1);
			i_mst.put({a, k[0]}, ak[2]);
			chk(ak[2], 1'b0);
			i_mst.stop();
			chk(bus_busy, 1'b0);
		end
		rd(8'h05, q);
		chk(q, mem[5]);
		wr(8'h06, 8'h00);
		for (int k = 0; k < 2; k++)
		begin
			wr(8'h05, k[7:0]);
			wr(8'h07, 8'h03 + k[7:0]);
			gap(1'b1, n);
			chk(n, 4096 * (k + 1));
			gap(1'b0, n);
			chk(n, 8 * (3 + k));
		end
		final_report();
	end
endmodule // two_wire_register_slave_bench
